// ==== inc/flash_ctl_pkg.sv ====
// Purpose: Shared constants and carrier types for the flash array control unit.
// Assumes: Byte-wide CPU bus with a 16-bit address, one bus clock.
// Notes: Addresses are the full CPU addresses that the block decodes.
package flash_ctl_pkg;
  localparam logic [15:0] ADDR_CTRL = 16'hFE0B;
  localparam logic [15:0] ADDR_ARRAY_LO = 16'h8000;
  localparam logic [15:0] ADDR_ARRAY_HI = 16'hFDFF;
  localparam logic [15:0] ADDR_PROT_LO = 16'hFF80;
  localparam logic [15:0] ADDR_PROT_HI = 16'hFF81;
  localparam logic [15:0] ADDR_VEC_LO = 16'hFFCC;
  localparam logic [15:0] ADDR_VEC_HI = 16'hFFFF;
  localparam logic [15:0] PROT_BASE_0 = 16'h8000;
  localparam logic [15:0] PROT_BASE_1 = 16'h9000;
  localparam logic [15:0] PROT_BASE_2 = 16'hA000;
  localparam logic [15:0] PROT_BASE_3 = 16'hC000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_DIV_HI = 7;
  localparam int BIT_DIV_LO = 6;
  localparam int BIT_SIZE_HI = 5;
  localparam int BIT_SIZE_LO = 4;
  localparam int BIT_HV = 3;
  localparam int BIT_MARGIN = 2;
  localparam int BIT_ERASE = 1;
  localparam int BIT_PROG = 0;
  localparam int PAGE_BYTES = 8;
  localparam int PAGES_PER_ROW = 8;
  localparam int ROW_BYTES = PAGE_BYTES * PAGES_PER_ROW;
  localparam int ROW_LAST = 511;
  localparam logic [3:0] MARGIN_STRETCH = 4'h8;
  localparam logic [1:0] SIZE_FULL = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_EIGHT_ROWS = 2'h2;
  localparam logic [1:0] SIZE_ROW = 2'h3;
  typedef struct packed {
    logic pump_div_hi;
    logic pump_div_lo;
    logic erase_size_hi;
    logic erase_size_lo;
    logic high_voltage_enable;
    logic margin_select;
    logic erase_select;
    logic program_select;
  } ctrl_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ARMED = 2'b01,
    SEQ_LATCHED = 2'b10,
    SEQ_CHECKED = 2'b11
  } seq_t;
endpackage : flash_ctl_pkg

// ==== hw/pump_divider.sv ====
// Purpose: Charge-pump clock divider from the bus clock.
// Assumes: Enable low holds the divider cleared.
// Notes: Output is a registered pump clock pulse, one bus cycle wide per pump period.
`timescale 1ns/100ps
`default_nettype none
module pump_divider (
  input wire logic ref_clk, // Bus clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic run, // Divider runs while high.
  input wire logic [1:0] div_sel, // Divide factor select.
  output logic pump_clk // Divided pump clock.
);
  logic [1:0] count;
  logic [1:0] next_count;
  logic next_pump_clk;
  // A pulse every cycle, every second or every fourth cycle gives divide by 1, 2 or 4.
  // A toggling level could not reach divide by 1, so the pump gates the bus clock with it.
  assign next_count = run ? count + 2'h1 : 2'h0;
  assign next_pump_clk = !run ? 1'b0 :
    (div_sel == 2'h0) ? 1'b1 :
    (div_sel == 2'h3) ? (next_count == 2'h3) : next_count[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 2'h0;
      pump_clk <= 1'b0;
    end else begin
      count <= next_count;
      pump_clk <= next_pump_clk;
    end
  end
endmodule : pump_divider
`default_nettype wire

// ==== hw/flash_array_control_unit.sv ====
// Purpose: Control register and interlocks for one flash array with its charge pump.
// Assumes: Byte-wide CPU bus, accesses one cycle long unless held by wait_req.
// Notes: Array data arrive on array_rdata and are passed back registered.
// What this block does
// - Erased bit reads 0, programmed reads 1.
// - Rows hold eight pages of eight bytes.
// - Smallest erase is one 64-byte row.
// - One program operation writes one page.
// - Decode array, control, protect and vector addresses.
// - Row n starts at 8000 plus 64n.
// - Control register byte, read-write, resets zero.
// - Pump clock divides bus by 1, 2, 4.
// - Block-size bits select erase region size.
// - High voltage set only after proper sequence.
// - High voltage bit drives pump and array.
// - Margin bit refused while high voltage on.
// - Erase and program never both set.
// - Program bit selects program operation.
// - Size codes: full, half, eight rows, row.
// - Protected range clears program or erase select.
// - Margin reads stretched by eight bus cycles.
`timescale 1ns/100ps
`default_nettype none
module flash_array_control_unit (
  input wire logic ref_clk, // Bus clock, 40 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire flash_ctl_pkg::bus_req_t bus_req, // CPU access request.
  input wire logic [7:0] array_rdata, // Data sensed from the array.
  input wire logic [3:0] protect_bits, // Block protect byte contents.
  output logic [7:0] bus_rdata, // Read data to the CPU.
  output logic wait_req, // Stretches the current read.
  output flash_ctl_pkg::ctrl_t ctrl, // Control register contents.
  output logic [1:0] erase_size, // Latched erase size code.
  output logic [15:0] op_addr, // Latched operation address.
  output logic array_wr, // Page latch write strobe.
  output logic [7:0] array_wdata, // Data for the page latch.
  output logic [2:0] page_offset, // Byte offset within the page.
  output logic hv_drive, // High voltage to the array.
  output logic pump_clk // Charge pump clock.
);
  flash_ctl_pkg::seq_t seq;
  flash_ctl_pkg::seq_t next_seq;
  flash_ctl_pkg::ctrl_t wreq;
  flash_ctl_pkg::ctrl_t next_ctrl;
  logic [3:0] stretch;
  logic [3:0] next_stretch;
  logic [3:0] prot_latched;
  logic [15:0] prot_base;
  logic hit_ctrl;
  logic hit_array;
  logic hit_prot;
  logic hit_vec;
  logic array_access;
  logic ctrl_wr;
  logic array_rd;
  logic op_on;
  logic range_end_hi;
  logic range_protected;
  logic hv_ok;
  logic new_prog;
  logic new_erase;
  logic [7:0] next_rdata;
  logic [15:0] range_hi;
  assign hit_ctrl = bus_req.sel && bus_req.addr == flash_ctl_pkg::ADDR_CTRL;
  assign hit_array = bus_req.addr >= flash_ctl_pkg::ADDR_ARRAY_LO &&
    bus_req.addr <= flash_ctl_pkg::ADDR_ARRAY_HI;
  assign hit_prot = bus_req.addr >= flash_ctl_pkg::ADDR_PROT_LO &&
    bus_req.addr <= flash_ctl_pkg::ADDR_PROT_HI;
  assign hit_vec = bus_req.addr >= flash_ctl_pkg::ADDR_VEC_LO;
  assign array_access = bus_req.sel && (hit_array || hit_vec);
  assign ctrl_wr = hit_ctrl && bus_req.wr;
  assign array_rd = array_access && !bus_req.wr;
  assign op_on = ctrl.program_select || ctrl.erase_select;
  assign wreq = flash_ctl_pkg::ctrl_t'(bus_req.wdata);
  // Region end for the latched operation: cared address bits kept, the rest set.
  always_comb begin
    range_hi = flash_ctl_pkg::ADDR_VEC_HI;
    if (ctrl.program_select) begin
      range_hi = {op_addr[15:3], 3'h7};
    end else begin
      unique case ({ctrl.erase_size_hi, ctrl.erase_size_lo})
        flash_ctl_pkg::SIZE_FULL: range_hi = flash_ctl_pkg::ADDR_VEC_HI;
        flash_ctl_pkg::SIZE_HALF: range_hi = {1'b1, op_addr[14], 14'h3FFF};
        flash_ctl_pkg::SIZE_EIGHT_ROWS: range_hi = {1'b1, op_addr[14:9], 9'h1FF};
        flash_ctl_pkg::SIZE_ROW: range_hi = {1'b1, op_addr[14:6], 6'h3F};
      endcase
    end
  end
  // Every protect region runs to the top of memory, so the lowest set bit gives the base.
  // A range touches a protected block as soon as its end reaches that base.
  assign prot_base = prot_latched[0] ? flash_ctl_pkg::PROT_BASE_0 :
    prot_latched[1] ? flash_ctl_pkg::PROT_BASE_1 :
    prot_latched[2] ? flash_ctl_pkg::PROT_BASE_2 : flash_ctl_pkg::PROT_BASE_3;
  assign range_end_hi = range_hi >= prot_base;
  assign range_protected = (prot_latched != 4'h0) && range_end_hi;
  assign hv_ok = op_on && seq == flash_ctl_pkg::SEQ_CHECKED;
  assign new_prog = wreq.program_select && !ctrl.erase_select;
  assign new_erase = wreq.erase_select && !ctrl.program_select &&
    !(wreq.program_select && !ctrl.erase_select);
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl = wreq;
      next_ctrl.program_select = new_prog;
      next_ctrl.erase_select = new_erase;
      next_ctrl.high_voltage_enable = wreq.high_voltage_enable && hv_ok;
    end
    if (next_ctrl.high_voltage_enable) begin
      next_ctrl.margin_select = 1'b0;
    end
    if (seq == flash_ctl_pkg::SEQ_CHECKED && op_on && range_protected &&
        !ctrl.high_voltage_enable) begin
      next_ctrl.program_select = 1'b0;
      next_ctrl.erase_select = 1'b0;
      next_ctrl.high_voltage_enable = 1'b0;
    end
  end
  // Sequence: select an operation, read the protect byte, then latch an address.
  always_comb begin
    next_seq = seq;
    if (!next_ctrl.program_select && !next_ctrl.erase_select) begin
      next_seq = flash_ctl_pkg::SEQ_IDLE;
    end else begin
      unique case (seq)
        flash_ctl_pkg::SEQ_IDLE: next_seq = flash_ctl_pkg::SEQ_ARMED;
        flash_ctl_pkg::SEQ_ARMED: begin
          if (bus_req.sel && hit_prot && !bus_req.wr) begin
            next_seq = flash_ctl_pkg::SEQ_LATCHED;
          end
        end
        flash_ctl_pkg::SEQ_LATCHED: begin
          if (array_access && bus_req.wr) begin
            next_seq = flash_ctl_pkg::SEQ_CHECKED;
          end
        end
        flash_ctl_pkg::SEQ_CHECKED: next_seq = seq;
      endcase
    end
  end
  // Margin reads hold the bus for eight extra cycles before data return.
  assign next_stretch = (stretch != 4'h0) ? stretch - 4'h1 :
    (array_rd && ctrl.margin_select && !wait_req) ? flash_ctl_pkg::MARGIN_STRETCH : 4'h0;
  assign next_rdata = hit_ctrl ? ctrl :
    (bus_req.sel && hit_prot) ? {4'h0, protect_bits} :
    array_access ? array_rdata : bus_rdata;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= flash_ctl_pkg::ctrl_t'(flash_ctl_pkg::CTRL_RESET);
      seq <= flash_ctl_pkg::SEQ_IDLE;
      stretch <= 4'h0;
      wait_req <= 1'b0;
      bus_rdata <= 8'h00;
      prot_latched <= 4'h0;
    end else begin
      ctrl <= next_ctrl;
      seq <= next_seq;
      stretch <= next_stretch;
      wait_req <= next_stretch != 4'h0;
      bus_rdata <= next_rdata;
      if (bus_req.sel && hit_prot && !bus_req.wr && op_on) begin
        prot_latched <= protect_bits;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_addr <= 16'h0000;
      erase_size <= 2'h0;
      array_wr <= 1'b0;
      array_wdata <= 8'h00;
      page_offset <= 3'h0;
      hv_drive <= 1'b0;
    end else begin
      if (array_access && bus_req.wr && op_on && !ctrl.high_voltage_enable) begin
        op_addr <= bus_req.addr;
      end
      erase_size <= {next_ctrl.erase_size_hi, next_ctrl.erase_size_lo};
      array_wr <= array_access && bus_req.wr && ctrl.program_select;
      array_wdata <= bus_req.wdata;
      page_offset <= bus_req.addr[2:0];
      hv_drive <= next_ctrl.high_voltage_enable;
    end
  end
  pump_divider u_pump_divider (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(ctrl.high_voltage_enable),
    .div_sel({ctrl.pump_div_hi, ctrl.pump_div_lo}),
    .pump_clk(pump_clk)
  );
endmodule : flash_array_control_unit
`default_nettype wire

// ==== dv/flash_ctl_props.sv ====
// Purpose: Port checks on the flash control unit.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every instance of the unit.
`timescale 1ns/100ps
`default_nettype none
module flash_ctl_props (
  input wire logic ref_clk, // Bus clock.
  input wire logic rst_n, // Reset, active low.
  input wire flash_ctl_pkg::bus_req_t bus_req, // Request.
  input wire logic [7:0] bus_rdata, // Read data.
  input wire logic wait_req, // Stretch.
  input wire flash_ctl_pkg::ctrl_t ctrl, // Register.
  input wire logic array_wr, // Page strobe.
  input wire logic hv_drive, // High voltage.
  input wire logic pump_clk // Pump clock.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic hv = ctrl.high_voltage_enable;
  wire logic rd = bus_req.sel && !bus_req.wr && !wait_req;
  wire logic wr_reg = bus_req.sel && bus_req.wr && bus_req.addr == flash_ctl_pkg::ADDR_CTRL;
  wire logic in_arr = bus_req.addr >= flash_ctl_pkg::ADDR_ARRAY_LO &&
    bus_req.addr <= flash_ctl_pkg::ADDR_ARRAY_HI;
  property p_hv_out; hv_drive == hv; endproperty
  a_hv_out: assert property (p_hv_out) else $error("hv drive differs");
  property p_excl; !(ctrl.erase_select && ctrl.program_select); endproperty
  a_excl: assert property (p_excl) else $error("erase and program both set");
  property p_margin; hv && $past(hv) |-> !ctrl.margin_select; endproperty
  a_margin: assert property (p_margin) else $error("margin set under hv");
  property p_idle; !hv && !$past(hv) |-> !pump_clk; endproperty
  a_idle: assert property (p_idle) else $error("pump clock while idle");
  property p_hv_sel; $rose(hv) |-> ctrl.erase_select || ctrl.program_select; endproperty
  a_hv_sel: assert property (p_hv_sel) else $error("hv without select");
  property p_fields; wr_reg |=> ctrl[7:4] == $past(bus_req.wdata[7:4]); endproperty
  a_fields: assert property (p_fields) else $error("field write lost");
  property p_stretch; rd && ctrl.margin_select && in_arr |=> wait_req [*8] ##1 !wait_req;
  endproperty
  a_stretch: assert property (p_stretch) else $error("margin stretch length");
  property p_rd_ctrl; rd && bus_req.addr == flash_ctl_pkg::ADDR_CTRL |=> bus_rdata == $past(ctrl);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("register read data");
  property p_conflict; ctrl.erase_select && wr_reg && bus_req.wdata[1:0] == 2'h3 |=>
    ctrl.erase_select && !ctrl.program_select; endproperty
  a_conflict: assert property (p_conflict) else $error("conflicting select taken");
  property p_wr_prog; array_wr |-> $past(ctrl.program_select); endproperty
  a_wr_prog: assert property (p_wr_prog) else $error("page strobe without program");
  c_hv: cover property ($rose(hv));
  c_wait: cover property ($rose(wait_req));
  c_wr: cover property (array_wr);
endmodule : flash_ctl_props
bind flash_array_control_unit flash_ctl_props flash_ctl_props_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .wait_req(wait_req),
  .ctrl(ctrl), .array_wr(array_wr), .hv_drive(hv_drive), .pump_clk(pump_clk));
`default_nettype wire

// ==== dv/flash_array_model.sv ====
// Purpose: Behavioural flash array behind the control unit.
// Assumes: One 64-byte row is enough for the bench.
// Notes: Programming only sets bits; reset erases.
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input wire logic ref_clk, // Bus clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic [15:0] addr, // Bus address.
  input wire logic array_wr, // Page strobe.
  input wire logic [7:0] array_wdata, // Page data.
  input wire logic [2:0] page_offset, // Byte in page.
  input wire logic [15:0] op_addr, // Latched address.
  output logic [7:0] array_rdata // Sensed data.
);
  logic [7:0] mem [0:63];
  assign array_rdata = mem[addr[5:0]];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 64; i++) mem[i] <= 8'h00;
    end else if (array_wr) begin
      mem[{op_addr[5:3], page_offset}] <= mem[{op_addr[5:3], page_offset}] | array_wdata;
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ==== dv/flash_array_control_unit_tb.sv ====
// Purpose: Directed bench for the flash control unit.
// Assumes: Single-cycle bus accesses, one idle cycle between.
// Notes: Array side is the behavioural model.
`timescale 1ns/100ps
`default_nettype none
module flash_array_control_unit_tb;
  localparam logic [15:0] CR = flash_ctl_pkg::ADDR_CTRL;
  localparam logic [15:0] PR = flash_ctl_pkg::ADDR_PROT_LO;
  logic ref_clk, rst_n, wait_req, array_wr, hv_drive, pump_clk;
  flash_ctl_pkg::bus_req_t bus_req;
  flash_ctl_pkg::ctrl_t ctrl;
  logic [7:0] array_rdata, bus_rdata, array_wdata, d;
  logic [3:0] protect_bits;
  logic [1:0] erase_size;
  logic [15:0] op_addr;
  logic [2:0] page_offset;
  int n_fail = 0, num_checks = 0, k, n;
  flash_array_control_unit flash_array_control_unit_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus_req(bus_req), .array_rdata(array_rdata), .protect_bits(protect_bits),
    .bus_rdata(bus_rdata), .wait_req(wait_req), .ctrl(ctrl), .erase_size(erase_size),
    .op_addr(op_addr), .array_wr(array_wr), .array_wdata(array_wdata),
    .page_offset(page_offset), .hv_drive(hv_drive), .pump_clk(pump_clk));
  flash_array_model flash_array_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(bus_req.addr), .array_wr(array_wr), .array_wdata(array_wdata),
    .page_offset(page_offset), .op_addr(op_addr), .array_rdata(array_rdata));
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bwr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk) bus_req <= {1'b1, 1'b1, a, v};
    @(posedge ref_clk) bus_req.sel <= 1'b0;
  endtask : bwr
  task automatic brd(input logic [15:0] a, output logic [7:0] v, output int w);
    @(posedge ref_clk) bus_req <= {1'b1, 1'b0, a, 8'h00};
    @(posedge ref_clk) bus_req.sel <= 1'b0;
    #1 w = 0;
    while (wait_req !== 1'b0 && w < 20) begin
      @(posedge ref_clk) #1 w++;
    end
    v = bus_rdata;
    if (w == 20) begin
      n_fail++;
      close_out();
    end
  endtask : brd
  task automatic pump_rises(output int r);
    logic p;
    r = 0;
    p = pump_clk;
    repeat (16) begin
      @(posedge ref_clk) #1 if (pump_clk === 1'b1 && p === 1'b0) r++;
      p = pump_clk;
    end
  endtask : pump_rises
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    protect_bits = 4'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    brd(CR, d, k); chk(d, 8'h00);
    bwr(CR, 8'hF0); brd(CR, d, k); chk(d, 8'hF0);
    chk(erase_size, flash_ctl_pkg::SIZE_ROW);
    bwr(CR, 8'h08); brd(CR, d, k); chk(d, 8'h00);
    bwr(CR, 8'h02); bwr(CR, 8'h03); brd(CR, d, k); chk(d, 8'h02);
    bwr(CR, 8'h00); bwr(CR, 8'hC1); brd(PR, d, k);
    for (int i = 0; i < 8; i++) bwr(16'h8000 + 16'(i), 8'h30 + 8'(i));
    bwr(CR, 8'hC9); brd(CR, d, k); chk(d, 8'hC9);
    chk(hv_drive, 1'b1);
    pump_rises(n); chk(16'(n), 16'h0004);
    bwr(CR, 8'h49); brd(CR, d, k); chk(d, 8'h49);
    pump_rises(n); chk(16'(n), 16'h0008);
    bwr(CR, 8'hCD); brd(CR, d, k); chk(d, 8'hC9);
    bwr(CR, 8'hC1); #1 chk(hv_drive, 1'b0);
    pump_rises(n); chk(16'(n), 16'h0000);
    bwr(CR, 8'hC5); brd(16'h8003, d, k); chk(d, 8'h33);
    chk(16'(k), 16'h0008);
    bwr(CR, 8'h00);
    protect_bits <= 4'h1;
    bwr(CR, 8'h01); brd(PR, d, k); bwr(16'h8040, 8'h01);
    brd(CR, d, k); chk(d, 8'h00);
    bwr(CR, 8'h09); brd(CR, d, k); chk(d, 8'h01);
    bwr(CR, 8'h00);
    protect_bits <= 4'h8;
    bwr(CR, 8'h02); brd(PR, d, k); bwr(16'h8000, 8'h00);
    brd(CR, d, k); chk(d, 8'h00);
    bwr(CR, 8'h32); brd(PR, d, k); bwr(16'h8040, 8'h00);
    bwr(CR, 8'h3A); brd(CR, d, k); chk(d, 8'h3A);
    chk(erase_size, flash_ctl_pkg::SIZE_ROW);
    close_out();
  end
endmodule : flash_array_control_unit_tb
`default_nettype wire
